//--- mode_resolve.sv
// derives effective speed, duplex and crossover from control and link state
`timescale 1ns/100ps
`default_nettype none
module mode_resolve
    import xcvr_ctrl_pkg::*;
(
    input wire logic [15:0] ctrl,
    input wire logic an_done,
    input wire logic an_failed,
    input wire logic an_speed,
    input wire logic an_duplex,
    input wire logic auto_x_choice,
    output logic speed_100,
    output logic full_duplex,
    output logic mdix
);
    wire logic an_on = ctrl[BIT_AN_EN];
    assign speed_100 = an_on ? an_speed : ctrl[BIT_SPEED];
    // failed negotiation falls back to the forced duplex
    assign full_duplex = (an_on && an_done && !an_failed) ? an_duplex : ctrl[BIT_DUPLEX];
    assign mdix = ctrl[BIT_NO_AUTO_X] ? ctrl[BIT_FORCE_X] : auto_x_choice;
endmodule : mode_resolve
`default_nettype wire

//--- port2_xcvr_ctrl.sv
// axi4-lite register block holding the port 2 transceiver control word
`timescale 1ns/100ps
`default_nettype none
// How it works
// - bit 15 set drives all four port 2 indicator pins high (off).
// - bit 14 set disables the port 2 transmitter.
// - writing 1 to bit 13 restarts auto-negotiation.
// - bit 10 set disables automatic crossover; reset value clear keeps it on.
// - with crossover auto off, bit 9 forces MDI-X mode.
// - bit 8 loops port 1 receive back at port 2 PMD/PMA to port 1.
// - bit 7 (reset 1) enables negotiation; else bits 6 and 5 decide.
// - negotiation off: bit 6 picks 100 or 10 Mbit/s.
// - negotiation off or failed: bit 5 picks full or half duplex.
// - bit 4 (reset 1) advertises pause capability.
// - bit 3 (reset 1) advertises 100 Mbit/s full duplex.
// - bit 2 (reset 1) advertises 100 Mbit/s half duplex.
// - bits 1 and 0 (reset 1) advertise 10 Mbit/s full and half.
module port2_xcvr_ctrl
    import xcvr_ctrl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [xcvr_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [xcvr_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] link_indicators,
    input wire logic an_done,
    input wire logic an_failed,
    input wire logic an_speed,
    input wire logic an_duplex,
    input wire logic auto_x_choice,
    output logic [3:0] port2_indicator_pins,
    output logic tx_disable,
    output logic restart_an_pulse,
    output logic power_down,
    output logic far_end_loopback,
    output logic an_enable,
    output logic speed_100,
    output logic full_duplex,
    output logic mdix,
    output logic [15:0] advertise
);
    typedef enum logic [1:0] {W_IDLE = 2'b00, W_RESP = 2'b01} wr_state_t;

    // merges write strobes of the low two lanes into a 16-bit word
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
        logic [15:0] r;
        r = old;
        if (st[0])
            r[7:0] = wd[7:0];
        if (st[1])
            r[15:8] = wd[15:8];
        return r;
    endfunction : merge16

    // places the bits of a standard view back into the control word
    function automatic logic [15:0] from_basic(input logic [15:0] old, input logic [15:0] v);
        logic [15:0] r;
        r = old;
        r[BIT_LED_OFF] = v[STD_LED_OFF];
        r[BIT_TX_DIS] = v[STD_TX_DIS];
        r[BIT_RSVD] = v[STD_RSVD];
        r[BIT_NO_AUTO_X] = v[STD_NO_AUTO_X];
        r[BIT_FORCE_X] = v[STD_FORCE_X];
        r[BIT_DUPLEX] = v[STD_DUPLEX];
        r[BIT_RESTART_AN] = v[STD_RESTART_AN];
        r[BIT_PWR_DOWN] = v[STD_PWR_DOWN];
        r[BIT_AN_EN] = v[STD_AN_EN];
        r[BIT_SPEED] = v[STD_SPEED];
        r[BIT_FAR_LOOP] = v[STD_FAR_LOOP];
        return r;
    endfunction : from_basic

    function automatic logic [15:0] from_adv(input logic [15:0] old, input logic [15:0] v);
        logic [15:0] r;
        r = old;
        r[BIT_ADV_10H] = v[STD_ADV_10H];
        r[BIT_ADV_10F] = v[STD_ADV_10F];
        r[BIT_ADV_100H] = v[STD_ADV_100H];
        r[BIT_ADV_100F] = v[STD_ADV_100F];
        r[BIT_ADV_PAUSE] = v[STD_ADV_PAUSE];
        return r;
    endfunction : from_adv

    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    wr_state_t wr_state_q;
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q;
    // handshake outputs kept in flops so no port is a decode of state
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [3:0] pins_q;
    logic tx_dis_q;
    logic restart_q;
    logic pwr_q;
    logic loop_q;
    logic an_q;
    logic speed_q;
    logic duplex_q;
    logic mdix_q;
    logic [15:0] adv_q;
    logic [15:0] basic_view;
    logic [15:0] adv_view;
    logic speed_w;
    logic duplex_w;
    logic mdix_w;

    view_map u_view_map (
        .ctrl(ctrl_q),
        .basic_view(basic_view),
        .adv_view(adv_view)
    );

    mode_resolve u_mode_resolve (
        .ctrl(ctrl_q),
        .an_done(an_done),
        .an_failed(an_failed),
        .an_speed(an_speed),
        .an_duplex(an_duplex),
        .auto_x_choice(auto_x_choice),
        .speed_100(speed_w),
        .full_duplex(duplex_w),
        .mdix(mdix_w)
    );

    // write side: address and data are latched independently, in any order
    wire logic aw_take = s_axi_awvalid && !aw_held_q && wr_state_q == W_IDLE;
    wire logic w_take = s_axi_wvalid && !w_held_q && wr_state_q == W_IDLE;
    wire logic have_aw = aw_held_q || aw_take;
    wire logic have_w = w_held_q || w_take;
    wire logic do_write = wr_state_q == W_IDLE && have_aw && have_w;
    wire logic [ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire logic [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
    wire logic [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
    wire logic wr_ctrl = do_write && wr_addr == CTRL_OFFSET;
    wire logic wr_basic = do_write && wr_addr == BASIC_OFFSET;
    wire logic wr_adv = do_write && wr_addr == ADV_OFFSET;
    wire logic wr_hit = wr_ctrl || wr_basic || wr_adv || (do_write && wr_addr == STAT_OFFSET);
    // restart is a write-one trigger: it self-clears one cycle after the write
    wire logic [15:0] ctrl_clr = {ctrl_q[15:14], 1'b0, ctrl_q[12:0]};
    wire logic [15:0] ctrl_wr = merge16(ctrl_clr, wr_data, wr_strb);
    wire logic [15:0] basic_wr = from_basic(ctrl_clr, merge16(basic_view, wr_data, wr_strb));
    wire logic [15:0] adv_wr = from_adv(ctrl_clr, merge16(adv_view, wr_data, wr_strb));

    // either view writes the same storage
    assign ctrl_d = wr_ctrl ? ctrl_wr : wr_basic ? basic_wr : wr_adv ? adv_wr : ctrl_clr;

    // read side
    wire logic ar_take = s_axi_arvalid && !rvalid_q;
    wire logic [15:0] status_view = {9'h000, an_failed, an_done, mdix_q, duplex_q, speed_q,
                                     an_q, pwr_q};
    wire logic rd_ctrl = s_axi_araddr == CTRL_OFFSET;
    wire logic rd_basic = s_axi_araddr == BASIC_OFFSET;
    wire logic rd_adv = s_axi_araddr == ADV_OFFSET;
    wire logic rd_stat = s_axi_araddr == STAT_OFFSET;
    wire logic rd_hit = rd_ctrl || rd_basic || rd_adv || rd_stat;
    wire logic [15:0] rd_word = rd_ctrl ? ctrl_q : rd_basic ? basic_view :
                                rd_adv ? adv_view : rd_stat ? status_view : 16'h0000;

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            ctrl_q <= CTRL_RESET;
            wr_state_q <= W_IDLE;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bresp_q <= RESP_OKAY;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            if (aw_take && !do_write)
            begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                awready_q <= 1'b0;
            end
            if (w_take && !do_write)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                wready_q <= 1'b0;
            end
            case (wr_state_q)
                W_IDLE:
                begin
                    if (do_write)
                    begin
                        wr_state_q <= W_RESP;
                        aw_held_q <= 1'b0;
                        w_held_q <= 1'b0;
                        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                        bvalid_q <= 1'b1;
                        awready_q <= 1'b0;
                        wready_q <= 1'b0;
                    end
                end
                W_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        wr_state_q <= W_IDLE;
                        bvalid_q <= 1'b0;
                        awready_q <= 1'b1;
                        wready_q <= 1'b1;
                    end
                end
                default:
                    wr_state_q <= W_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_q <= 1'b1;
            arready_q <= 1'b0;
            rdata_q <= {16'h0000, rd_word};
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // registered transceiver controls; one cycle behind the control word
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            pins_q <= 4'hf;
            tx_dis_q <= 1'b0;
            restart_q <= 1'b0;
            pwr_q <= 1'b0;
            loop_q <= 1'b0;
            an_q <= 1'b1;
            speed_q <= 1'b0;
            duplex_q <= 1'b0;
            mdix_q <= 1'b0;
            adv_q <= 16'h0000;
        end
        else
        begin
            pins_q <= ctrl_q[BIT_LED_OFF] ? 4'hf : link_indicators;
            tx_dis_q <= ctrl_q[BIT_TX_DIS] | ctrl_q[BIT_PWR_DOWN];
            restart_q <= ctrl_q[BIT_RESTART_AN];
            pwr_q <= ctrl_q[BIT_PWR_DOWN];
            loop_q <= ctrl_q[BIT_FAR_LOOP];
            an_q <= ctrl_q[BIT_AN_EN];
            speed_q <= speed_w;
            duplex_q <= duplex_w;
            mdix_q <= mdix_w;
            adv_q <= adv_view;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign port2_indicator_pins = pins_q;
    assign tx_disable = tx_dis_q;
    assign restart_an_pulse = restart_q;
    assign power_down = pwr_q;
    assign far_end_loopback = loop_q;
    assign an_enable = an_q;
    assign speed_100 = speed_q;
    assign full_duplex = duplex_q;
    assign mdix = mdix_q;
    assign advertise = adv_q;
endmodule : port2_xcvr_ctrl
`default_nettype wire

//--- port2_xcvr_ctrl_assertions.sv
// checker for the port 2 transceiver control block
`timescale 1ns/100ps
`default_nettype none
module port2_xcvr_ctrl_chk
    import xcvr_ctrl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [xcvr_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [3:0] link_indicators,
    input wire logic an_done,
    input wire logic an_failed,
    input wire logic an_speed,
    input wire logic an_duplex,
    input wire logic [3:0] port2_indicator_pins,
    input wire logic tx_disable,
    input wire logic restart_an_pulse,
    input wire logic power_down,
    input wire logic far_end_loopback,
    input wire logic an_enable,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic [15:0] advertise
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_ctrl_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr == CTRL_OFFSET && s_axi_wstrb == 4'h3;
    endsequence
    sequence s_pulse;
        restart_an_pulse ##1 !restart_an_pulse;
    endsequence
    property p_led_off;
        s_ctrl_wr ##0 s_axi_wdata[15] |-> ##2 port2_indicator_pins == 4'hf;
    endproperty
    a_led_off: assert property (p_led_off) else $error("indicators not off");
    property p_led_pass;
        port2_indicator_pins != 4'hf |-> port2_indicator_pins == $past(link_indicators);
    endproperty
    a_led_pass: assert property (p_led_pass) else $error("indicator mismatch");
    property p_fields;
        s_ctrl_wr |-> ##2 (tx_disable == ($past(s_axi_wdata[14], 2) || $past(s_axi_wdata[11], 2))
            && power_down == $past(s_axi_wdata[11], 2)
            && far_end_loopback == $past(s_axi_wdata[8], 2)
            && an_enable == $past(s_axi_wdata[7], 2));
    endproperty
    a_fields: assert property (p_fields) else $error("control field wrong");
    property p_restart;
        s_ctrl_wr ##0 s_axi_wdata[13] |-> ##2 s_pulse;
    endproperty
    a_restart: assert property (p_restart) else $error("restart pulse wrong");
    property p_an_speed;
        an_enable && $past(reset_n) |-> speed_100 == $past(an_speed);
    endproperty
    a_an_speed: assert property (p_an_speed) else $error("speed wrong");
    property p_an_duplex;
        an_enable && $past(reset_n && an_done && !an_failed) |-> full_duplex == $past(an_duplex);
    endproperty
    a_an_duplex: assert property (p_an_duplex) else $error("duplex wrong");
    property p_pd_tx;
        power_down |-> tx_disable;
    endproperty
    a_pd_tx: assert property (p_pd_tx) else $error("transmitter on in power-down");
    property p_adv;
        (advertise & 16'hfa1f) == 16'h0000;
    endproperty
    a_adv: assert property (p_adv) else $error("stray advert bit");
    property p_adv_map;
        s_ctrl_wr |-> ##2 advertise == {5'h00, $past(s_axi_wdata[4], 2), 1'b0,
            $past(s_axi_wdata[3], 2), $past(s_axi_wdata[2], 2), $past(s_axi_wdata[1], 2),
            $past(s_axi_wdata[0], 2), 5'h00};
    endproperty
    a_adv_map: assert property (p_adv_map) else $error("bad advert");
endmodule : port2_xcvr_ctrl_chk
bind port2_xcvr_ctrl port2_xcvr_ctrl_chk u_chk (.ref_clk, .reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .link_indicators, .an_done, .an_failed, .an_speed, .an_duplex, .port2_indicator_pins,
    .tx_disable, .restart_an_pulse, .power_down, .far_end_loopback, .an_enable, .speed_100,
    .full_duplex, .advertise);
`default_nettype wire

//--- test_port2_xcvr_ctrl.sv
// self-checking bench for the port 2 transceiver control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_port2_xcvr_ctrl;
    import xcvr_ctrl_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 4'h3, link_indicators = 4'ha, port2_indicator_pins;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, auto_x_choice = 1'b0;
    logic an_done = 1'b0, an_failed = 1'b0, an_speed = 1'b0, an_duplex = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tx_disable, restart_an_pulse, power_down, far_end_loopback, an_enable;
    logic speed_100, full_duplex, mdix;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [15:0] advertise;
    int err_count = 0;
    int total_checks = 0;
    int adv_src [5] = '{4, 3, 2, 1, 0};
    int adv_dst [5] = '{10, 8, 7, 6, 5};
    port2_xcvr_ctrl u_dut (.ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .link_indicators, .an_done, .an_failed, .an_speed,
        .an_duplex, .auto_x_choice, .port2_indicator_pins, .tx_disable, .restart_an_pulse,
        .power_down, .far_end_loopback, .an_enable, .speed_100, .full_duplex, .mdix, .advertise);
    always #20 ref_clk = ~ref_clk;
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    // ready and valid are looked at mid-cycle, where they equal what the next edge samples
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d);
        int n;
        logic ta, tw, tr, done;
        n = 0;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        while (!done)
        begin
            @(negedge ref_clk);
            n++;
            if (n > 50)
            begin
                err_count++;
                print_verdict();
            end
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tr = s_axi_arvalid && s_axi_arready;
            done = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
            q = s_axi_rdata;
            r = w ? s_axi_bresp : s_axi_rresp;
            @(posedge ref_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tr) s_axi_arvalid <= 1'b0;
            if (done) s_axi_bready <= 1'b0;
            if (done) s_axi_rready <= 1'b0;
        end
    endtask : xfer
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic [1:0] e);
        xfer(1'b1, a, d);
        `CHK(r, e)
        repeat (2) @(negedge ref_clk);
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] e);
        xfer(1'b0, a, 16'h0000);
        `CHK(r, e)
        `CHK(q, ed)
    endtask : rd
    initial
    begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(negedge ref_clk);
        `CHK({port2_indicator_pins, an_enable, advertise}, 21'h1505e0)
        rd(CTRL_OFFSET, 32'h0000009f, RESP_OKAY);
        wr(CTRL_OFFSET, 16'h8000, RESP_OKAY);
        `CHK(port2_indicator_pins, 4'hf)
        `CHK({an_enable, speed_100, full_duplex, advertise}, 19'h0)
        wr(CTRL_OFFSET, 16'h0060, RESP_OKAY);
        `CHK({port2_indicator_pins, speed_100, full_duplex}, 6'h2b)
        @(posedge ref_clk);
        link_indicators <= 4'h5;
        repeat (2) @(negedge ref_clk);
        `CHK(port2_indicator_pins, 4'h5)
        wr(CTRL_OFFSET, 16'h4100, RESP_OKAY);
        `CHK({tx_disable, power_down, far_end_loopback}, 3'b101)
        wr(CTRL_OFFSET, 16'h1800, RESP_OKAY);
        `CHK({tx_disable, power_down, far_end_loopback}, 3'b110)
        rd(CTRL_OFFSET, 32'h00001800, RESP_OKAY);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge ref_clk);
            auto_x_choice <= i[0];
            wr(CTRL_OFFSET, {5'h00, i[2:1], 9'h000}, RESP_OKAY);
            `CHK(mdix, i[2] ? i[1] : i[0])
        end
        xfer(1'b1, CTRL_OFFSET, 16'h2080);
        @(negedge ref_clk);
        `CHK(restart_an_pulse, 1'b1)
        @(negedge ref_clk);
        `CHK(restart_an_pulse, 1'b0)
        rd(CTRL_OFFSET, 32'h00000080, RESP_OKAY);
        @(posedge ref_clk);
        an_speed <= 1'b1;
        an_done <= 1'b1;
        an_duplex <= 1'b1;
        repeat (2) @(negedge ref_clk);
        `CHK({an_enable, speed_100, full_duplex}, 3'b111)
        @(posedge ref_clk);
        an_failed <= 1'b1;
        repeat (2) @(negedge ref_clk);
        `CHK(full_duplex, 1'b0)
        for (int i = 0; i < 5; i++)
        begin
            wr(CTRL_OFFSET, 16'h0001 << adv_src[i], RESP_OKAY);
            `CHK(advertise, 16'h0001 << adv_dst[i])
        end
        wr(CTRL_OFFSET, 16'h0000, RESP_OKAY);
        wr(BASIC_OFFSET, 16'h1001, RESP_OKAY);
        wr(ADV_OFFSET, 16'h0400, RESP_OKAY);
        rd(CTRL_OFFSET, 32'h00008090, RESP_OKAY);
        rd(BASIC_OFFSET, 32'h00001001, RESP_OKAY);
        rd(ADV_OFFSET, 32'h00000400, RESP_OKAY);
        rd(STAT_OFFSET, 32'h00000076, RESP_OKAY);
        wr(8'h40, 16'h1234, RESP_SLVERR);
        rd(8'h40, 32'h00000000, RESP_SLVERR);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(CTRL_OFFSET, 32'h0000009f, RESP_OKAY);
        print_verdict();
    end
endmodule : test_port2_xcvr_ctrl
`default_nettype wire

//--- view_map.sv
// maps the control word onto the standard basic and advert views
`timescale 1ns/100ps
`default_nettype none
module view_map
    import xcvr_ctrl_pkg::*;
(
    input wire logic [15:0] ctrl,
    output logic [15:0] basic_view,
    output logic [15:0] adv_view
);
    assign basic_view = 16'(
        (32'(ctrl[BIT_LED_OFF]) << STD_LED_OFF) | (32'(ctrl[BIT_TX_DIS]) << STD_TX_DIS)
        | (32'(ctrl[BIT_RSVD]) << STD_RSVD) | (32'(ctrl[BIT_NO_AUTO_X]) << STD_NO_AUTO_X)
        | (32'(ctrl[BIT_FORCE_X]) << STD_FORCE_X) | (32'(ctrl[BIT_DUPLEX]) << STD_DUPLEX)
        | (32'(ctrl[BIT_RESTART_AN]) << STD_RESTART_AN)
        | (32'(ctrl[BIT_PWR_DOWN]) << STD_PWR_DOWN) | (32'(ctrl[BIT_AN_EN]) << STD_AN_EN)
        | (32'(ctrl[BIT_SPEED]) << STD_SPEED) | (32'(ctrl[BIT_FAR_LOOP]) << STD_FAR_LOOP));
    assign adv_view = 16'(
        (32'(ctrl[BIT_ADV_10H]) << STD_ADV_10H) | (32'(ctrl[BIT_ADV_10F]) << STD_ADV_10F)
        | (32'(ctrl[BIT_ADV_100H]) << STD_ADV_100H) | (32'(ctrl[BIT_ADV_100F]) << STD_ADV_100F)
        | (32'(ctrl[BIT_ADV_PAUSE]) << STD_ADV_PAUSE));
endmodule : view_map
`default_nettype wire

//--- xcvr_ctrl_pkg.sv
// constants for the port 2 transceiver control register block
package xcvr_ctrl_pkg;
    localparam int ADDR_W = 8;
    // word index of the control register; its byte address is four times it
    localparam logic [ADDR_W-1:0] CTRL_INDEX = 8'h02;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = ADDR_W'(CTRL_INDEX * 4);
    localparam logic [ADDR_W-1:0] BASIC_OFFSET = 8'h10;
    localparam logic [ADDR_W-1:0] ADV_OFFSET = 8'h14;
    localparam logic [ADDR_W-1:0] STAT_OFFSET = 8'h18;
    localparam logic [15:0] CTRL_RESET = 16'h009f;
    localparam int BIT_LED_OFF = 15;
    localparam int BIT_TX_DIS = 14;
    localparam int BIT_RESTART_AN = 13;
    localparam int BIT_RSVD = 12;
    localparam int BIT_PWR_DOWN = 11;
    localparam int BIT_NO_AUTO_X = 10;
    localparam int BIT_FORCE_X = 9;
    localparam int BIT_FAR_LOOP = 8;
    localparam int BIT_AN_EN = 7;
    localparam int BIT_SPEED = 6;
    localparam int BIT_DUPLEX = 5;
    localparam int BIT_ADV_PAUSE = 4;
    localparam int BIT_ADV_100F = 3;
    localparam int BIT_ADV_100H = 2;
    localparam int BIT_ADV_10F = 1;
    localparam int BIT_ADV_10H = 0;
    // standard-view bit positions
    localparam int STD_LED_OFF = 0;
    localparam int STD_TX_DIS = 1;
    localparam int STD_RSVD = 2;
    localparam int STD_NO_AUTO_X = 3;
    localparam int STD_FORCE_X = 4;
    localparam int STD_DUPLEX = 8;
    localparam int STD_RESTART_AN = 9;
    localparam int STD_PWR_DOWN = 11;
    localparam int STD_AN_EN = 12;
    localparam int STD_SPEED = 13;
    localparam int STD_FAR_LOOP = 14;
    localparam int STD_ADV_10H = 5;
    localparam int STD_ADV_10F = 6;
    localparam int STD_ADV_100H = 7;
    localparam int STD_ADV_100F = 8;
    localparam int STD_ADV_PAUSE = 10;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : xcvr_ctrl_pkg
